// ---- common/card_rx_pkg.sv ----
// Constants for the two-line card reader receiver
package card_rx_pkg;
  localparam int          CLK_MHZ       = 100;
  localparam int          CNT_W         = 8;
  localparam int          READERS       = 4;
  localparam int          SYNC_STAGES   = 3;
  localparam logic [2:0]  BIT_IDX_MSB   = 3'h7;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [7:0]  CNT_ONE       = 8'h01;
  localparam logic [1:0]  LINES_IDLE    = 2'h3;
  localparam logic [1:0]  SYNC_ZERO     = 2'h0;
  localparam logic [2:0]  SYNC_IDLE     = 3'h7;
  localparam logic [2:0]  SYNC_LOW      = 3'h0;
  localparam int          WD_PERIOD_NS  = 1000;
  localparam int          WD_CYCLES     = (WD_PERIOD_NS * CLK_MHZ) / 1000;
  localparam logic [15:0] WD_RELOAD     = 16'(WD_CYCLES - 1);
  localparam logic [15:0] WD_ZERO       = 16'h0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } rx_state_t;
endpackage

// ---- verilog/card_rx.sv ----
// Two-line pulse-coded card reader receiver with output buffer
`timescale 1ns/1ps
module card_rx #(
  parameter int CNT_W = card_rx_pkg::CNT_W
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_zero_n,
  input  wire logic             i_one_n,
  input  wire logic             i_timeout,
  input  wire logic             i_start,
  input  wire logic [CNT_W-1:0] i_bit_count,
  output logic                  o_busy,
  output logic                  o_done,
  output logic [CNT_W-1:0]      o_stored,
  output logic                  o_byte_valid,
  output logic [7:0]            o_byte,
  input  wire logic             i_byte_ready,
  output logic                  o_wd_kick
);
  import card_rx_pkg::*;

  typedef struct packed {
    logic [2:0]       s0;
    logic [2:0]       s1;
    logic [2:0]       st;
    rx_state_t        state;
    logic [CNT_W-1:0] target;
    logic [CNT_W-1:0] stored;
    logic [7:0]       shift;
    logic [2:0]       nbits;
    logic [7:0]       b0;
    logic [7:0]       b1;
    logic [1:0]       bcnt;
    logic             done;
    logic [15:0]      wd;
    logic             kick;
    logic             busy;
    logic             valid;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [7:0] shifted;
  logic [7:0] push_byte;
  logic       zero_fall;
  logic       one_fall;
  logic       zero_low;
  logic       one_low;
  logic       to_hi;
  logic       quiet;
  logic       one_act;
  logic       accept;
  logic       push;
  logic       pop;
  logic       room;
  logic       last;
  logic       got;
  logic       bitv;

  always_comb begin
    st_nxt = st_r;
    // Three stages, a fall is accepted while stage 2 is low and stage 3 is still high
    st_nxt.s0 = {st_r.s0[1:0], i_zero_n};
    st_nxt.s1 = {st_r.s1[1:0], i_one_n};
    st_nxt.st = {st_r.st[1:0], i_timeout};
    // Sampled every clock
    zero_low  = (st_r.s0[2:1] == SYNC_ZERO);
    one_low   = (st_r.s1[2:1] == SYNC_ZERO);
    zero_fall = (st_r.s0[2:1] == 2'b10);
    one_fall  = (st_r.s1[2:1] == 2'b10);
    to_hi     = (st_r.st[2:1] == 2'b11);
    quiet     = st_r.s0[1] && st_r.s1[1];
    one_act   = (st_r.s1[2:1] != LINES_IDLE);
    got       = zero_fall | one_fall;
    bitv      = one_fall;
    room      = (st_r.bcnt != 2'd2);
    accept    = (st_r.state == ST_WAIT) && got && room &&
                (st_r.stored != st_r.target);
    pop       = st_r.valid && i_byte_ready;
    push      = 1'b0;
    last      = 1'b0;
    shifted   = {st_r.shift[6:0], bitv};
    push_byte = shifted;
    st_nxt.done = 1'b0;
    st_nxt.kick = 1'b0;
    case (st_r.state)
      ST_IDLE: begin
        if (i_start) begin
          st_nxt.target = i_bit_count;
          st_nxt.stored = '0;
          st_nxt.shift  = BYTE_ZERO;
          st_nxt.nbits  = 3'h0;
          st_nxt.wd     = WD_RELOAD;
          if ({st_r.s1[2], st_r.s0[2]} == LINES_IDLE &&
              !zero_fall && !one_fall) begin
            st_nxt.done = 1'b1;
          end else if (i_bit_count == '0) begin
            st_nxt.done = 1'b1;
          end else begin
            // Pulse in flight is the first bit
            st_nxt.stored = CNT_ONE[CNT_W-1:0];
            st_nxt.shift  = {BYTE_ZERO[7:1], one_act};
            st_nxt.nbits  = 3'h1;
            st_nxt.state  = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (st_r.wd == WD_ZERO) begin
          st_nxt.kick = 1'b1;
          st_nxt.wd   = WD_RELOAD;
        end else begin
          st_nxt.wd = st_r.wd - 16'h0001;
        end
        if (st_r.stored == st_r.target) begin
          // Request met by the first bit alone
          if (room) begin
            push         = 1'b1;
            push_byte    = st_r.shift;
            st_nxt.shift = BYTE_ZERO;
            st_nxt.nbits = 3'h0;
            st_nxt.state = ST_DONE;
          end
        end else if (accept) begin
          st_nxt.stored = st_r.stored + CNT_ONE[CNT_W-1:0];
          st_nxt.nbits  = st_r.nbits + 3'h1;
          st_nxt.shift  = shifted;
          last = (st_r.stored + CNT_ONE[CNT_W-1:0] == st_r.target);
          if (st_r.nbits == BIT_IDX_MSB || last) begin
            push         = 1'b1;
            st_nxt.shift = BYTE_ZERO;
            st_nxt.nbits = 3'h0;
          end
          if (last) begin
            st_nxt.state = ST_DONE;
          end
        end else if (to_hi && quiet) begin
          // Flush a partial byte before finishing
          if (st_r.nbits != 3'h0 && room) begin
            push         = 1'b1;
            push_byte    = st_r.shift;
            st_nxt.state = ST_DONE;
          end else if (st_r.nbits == 3'h0) begin
            st_nxt.state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        st_nxt.done  = 1'b1;
        st_nxt.state = ST_IDLE;
      end
      default: st_nxt.state = ST_IDLE;
    endcase
    // Two-entry output buffer
    if (pop) begin
      st_nxt.b0 = st_r.b1;
    end
    if (push && pop) begin
      if (st_r.bcnt == 2'd1) st_nxt.b0 = push_byte;
      else st_nxt.b1 = push_byte;
    end else if (push) begin
      if (st_r.bcnt == 2'd0) st_nxt.b0 = push_byte;
      else st_nxt.b1 = push_byte;
      st_nxt.bcnt = st_r.bcnt + 2'd1;
    end else if (pop) begin
      st_nxt.bcnt = st_r.bcnt - 2'd1;
    end
    // Registered copies for the outputs
    st_nxt.busy  = (st_nxt.state != ST_IDLE);
    st_nxt.valid = (st_nxt.bcnt != 2'd0);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r       <= '0;
      st_r.s0    <= SYNC_IDLE;
      st_r.s1    <= SYNC_IDLE;
      st_r.st    <= SYNC_LOW;
      st_r.state <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_busy       = st_r.busy;
  assign o_done       = st_r.done;
  assign o_stored     = st_r.stored;
  assign o_byte_valid = st_r.valid;
  assign o_byte       = st_r.b0;
  assign o_wd_kick    = st_r.kick;

  stored_limit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_busy |-> o_stored <= st_r.target)
    else $error("stored count above target");
  done_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_done |=> !o_done)
    else $error("done longer than one cycle");
  idle_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r.state == ST_IDLE && i_start && st_r.s0[2] && st_r.s1[2] &&
     !zero_fall && !one_fall) |=> (o_done && o_stored == '0))
    else $error("idle start did not finish empty");
  bit_count_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    accept |=>
      o_stored == $past(o_stored) + CNT_ONE[CNT_W-1:0])
    else $error("pulse not counted");
  one_value_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (accept && one_fall && !push) |=>
      st_r.shift[0])
    else $error("one pulse stored as zero");
  zero_value_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (accept && zero_fall && !push) |=>
      !st_r.shift[0])
    else $error("zero pulse stored as one");
  timeout_end_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r.state == ST_WAIT && to_hi && !got && !zero_low && !one_low &&
     st_r.nbits == 3'h0) |=> ##1 o_done)
    else $error("timeout did not end reception");
  timeout_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r.state == ST_WAIT && (zero_low || one_low) && !got &&
     st_r.stored != st_r.target) |=>
      st_r.state == ST_WAIT)
    else $error("timeout acted during pulse");
  kick_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_wd_kick |-> $past(st_r.state) == ST_WAIT)
    else $error("kick outside wait");
  buf_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.bcnt <= 2'd2)
    else $error("buffer overfilled");

  rx_full_c: cover property (@(posedge i_clk) o_done && o_stored != '0);
  rx_idle_c: cover property (@(posedge i_clk)
    i_start && !o_busy ##1 o_done && o_stored == '0);
  buf_stall_c: cover property (@(posedge i_clk)
    st_r.bcnt == 2'd2 && !i_byte_ready);
  kick_c: cover property (@(posedge i_clk) o_wd_kick);
endmodule // card_rx

// ---- dv/card_reader_model.sv ----
// Behavioural card reader driving the zero and one pulse lines
`timescale 1ns/1ps
module card_reader_model #(
  parameter int GAP_CYC = 15000
) (
  input  wire logic i_clk,
  output logic      o_zero_n,
  output logic      o_one_n
);
  initial begin
    o_zero_n = 1'b1;
    o_one_n  = 1'b1;
  end
  // One low pulse on one line, then the rest of the bit slot if tail is set, else 20 cycles
  task automatic send_bit(input logic b, input int low_cyc,
                         input logic tail);
    @(posedge i_clk);
    #1;
    if (b) o_one_n = 1'b0; else o_zero_n = 1'b0;
    repeat (low_cyc) @(posedge i_clk);
    #1;
    o_zero_n = 1'b1;
    o_one_n  = 1'b1;
    if (tail) begin
      repeat (GAP_CYC - low_cyc) @(posedge i_clk);
    end else begin
      repeat (20) @(posedge i_clk);
    end
  endtask
endmodule // card_reader_model

// ---- dv/card_reader_two_line_receiver_tb_top.sv ----
// Self-checking bench for the two-line card reader receiver
`timescale 1ns/1ps
module card_reader_two_line_receiver_tb_top;
  import card_rx_pkg::*;
  logic       i_clk;
  logic       i_rst_n;
  logic       i_timeout;
  logic       i_start;
  logic       i_byte_ready;
  logic [7:0] i_bit_count;
  logic       zero_n;
  logic       one_n;
  logic       o_busy;
  logic       o_done;
  logic [7:0] o_stored;
  logic       o_byte_valid;
  logic [7:0] o_byte;
  logic       o_wd_kick;
  logic [7:0] last_stored;
  int         mismatches = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         kicks = 0;
  int         done_cnt = 0;
  card_rx u_card_rx (
    .i_clk, .i_rst_n, .i_zero_n(zero_n), .i_one_n(one_n), .i_timeout,
    .i_start, .i_bit_count, .o_busy, .o_done, .o_stored, .o_byte_valid,
    .o_byte, .i_byte_ready, .o_wd_kick
  );
  card_reader_model u_card_reader_model (
    .i_clk, .o_zero_n(zero_n), .o_one_n(one_n)
  );
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (o_wd_kick === 1'b1) kicks++;
    if (o_done === 1'b1) begin
      done_cnt++;
      last_stored = o_stored;
    end
    if (cycles == 98000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic check(input string nm, input logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic start_rx(input logic [7:0] n);
    i_bit_count = n;
    i_start = 1'b1;
    @(posedge i_clk);
    #1;
    i_start = 1'b0;
  endtask
  task automatic test_idle();
    done_cnt = 0;
    start_rx(8'h08);
    repeat (3) @(posedge i_clk);
    #1;
    check("done_cnt", 8'h01, 8'(done_cnt));
    check("stored", 8'h00, last_stored);
  endtask
  task automatic test_byte();
    logic [7:0] pat;
    pat = 8'hB4;
    done_cnt = 0;
    kicks = 0;
    fork
      u_card_reader_model.send_bit(pat[5], 1000, 1'b1);
      begin
        repeat (10) @(posedge i_clk);
        #1;
        start_rx(8'h06);
      end
    join
    for (int i = 4; i >= 0; i--) begin
      u_card_reader_model.send_bit(pat[i], 1000, 1'b1);
    end
    check("done_cnt", 8'h01, 8'(done_cnt));
    check("stored", 8'h06, last_stored);
    check("busy", 8'h00, {7'h00, o_busy});
    check("valid", 8'h01, {7'h00, o_byte_valid});
    check("byte", {2'b00, pat[5:0]}, o_byte);
    check("kick", 8'h01, {7'h00, kicks > 0});
    i_byte_ready = 1'b1;
    @(posedge i_clk);
    #1;
    i_byte_ready = 1'b0;
    check("valid", 8'h00, {7'h00, o_byte_valid});
  endtask
  task automatic test_timeout();
    done_cnt = 0;
    fork
      u_card_reader_model.send_bit(1'b1, 1000, 1'b0);
      begin
        repeat (10) @(posedge i_clk);
        #1;
        start_rx(8'h08);
        i_timeout = 1'b1;
        repeat (500) @(posedge i_clk);
        #1;
        check("busy", 8'h01, {7'h00, o_busy});
      end
    join
    i_timeout = 1'b0;
    check("done_cnt", 8'h01, 8'(done_cnt));
    check("stored", 8'h01, last_stored);
    check("valid", 8'h01, {7'h00, o_byte_valid});
    check("flush", 8'h01, o_byte);
  endtask
  task automatic summarize();
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_timeout = 1'b0;
    i_start = 1'b0;
    i_byte_ready = 1'b0;
    i_bit_count = 8'h00;
    repeat (20) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    test_idle();
    test_byte();
    test_timeout();
    summarize();
  end
endmodule // card_reader_two_line_receiver_tb_top
